// [drc_pkg.sv]
/*
  Constants for the disturbance recorder capture block: register map,
  field positions, reset values, setting ranges and timing counts.
  Assumes a 100 MHz system clock shared by all users of the package.
*/
`default_nettype none
package drc_pkg;
  // bus and clock
  localparam int ADDR_W = 8;
  localparam int CLK_MHZ = 100;
  localparam int MS_NS = 1000000; // one millisecond in ns
  localparam int MS_CYCLES = MS_NS * CLK_MHZ / 1000;
  // channel counts and sample layout
  localparam int ANA_CH = 32;
  localparam int BIN_CH = 64;
  localparam int ANA_W = 16;
  localparam int FRAME_W = ANA_CH * ANA_W + BIN_CH;
  localparam int FRAME_BYTES = FRAME_W / 8;
  localparam int MEM_BYTES = 12 * 1024 * 1024; // shared record memory
  localparam int FRAMES = MEM_BYTES / FRAME_BYTES;
  localparam int PTR_W = 18;
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(FRAMES - 1);
  // millisecond history ring
  localparam int HIST_W = 10;
  localparam int HIST_D = 1 << HIST_W;
  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_PRE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_POST = 8'h08;
  localparam logic [ADDR_W-1:0] REG_MAX = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_ANA_EN = 8'h10;
  localparam logic [ADDR_W-1:0] REG_BIN_EN_LO = 8'h14;
  localparam logic [ADDR_W-1:0] REG_BIN_EN_HI = 8'h18;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h20;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h24;
  localparam logic [ADDR_W-1:0] REG_REC_START = 8'h28;
  localparam logic [ADDR_W-1:0] REG_REC_END = 8'h2C;
  localparam logic [ADDR_W-1:0] REG_REC_COUNT = 8'h30;
  // control fields
  localparam int CTRL_OPER = 0;
  localparam int CTRL_RATE = 1;
  // interrupt events
  localparam int IRQ_W = 3;
  localparam int EV_START = 0;
  localparam int EV_DONE = 1;
  localparam int EV_WARN = 2;
  // timer settings in ms
  localparam int TIME_W = 14;
  localparam logic [TIME_W-1:0] PRE_MIN = 14'd100;
  localparam logic [TIME_W-1:0] PRE_MAX = 14'd1000;
  localparam logic [TIME_W-1:0] PRE_DEF = 14'd200;
  localparam logic [TIME_W-1:0] POST_MIN = 14'd100;
  localparam logic [TIME_W-1:0] POST_MAX = 14'd1000;
  localparam logic [TIME_W-1:0] POST_DEF = 14'd200;
  localparam logic [TIME_W-1:0] MAXT_MIN = 14'd500;
  localparam logic [TIME_W-1:0] MAXT_MAX = 14'd10000;
  localparam logic [TIME_W-1:0] MAXT_DEF = 14'd1000;
  typedef enum logic [1:0] {DRC_OFF, DRC_ARMED, DRC_TRIG, DRC_POST} drc_state_type;
endpackage : drc_pkg
`default_nettype wire

// [drc_capture.sv]
/*
  Disturbance recorder capture controller: APB register slave, circular
  sample history, trigger/post sequencing and record memory write port.
  Assumes the start condition, sample tick and sample data come from
  logic on CLK, and that the record memory accepts one frame per cycle.
*/
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Function
// - record only when operation on and start true
// - capture while start active, bounded by limit
// - up to 64 binary, 32 analogue channels
// - twelve megabyte record memory shared by records
// - basic variant twenty samples per period, default
// - selectable variant twenty or forty, default twenty
// - pre-trigger history 100 to 1000 ms
// - triggered section limited 500 to 10000 ms
// - post-trigger capture 100 to 1000 ms
// - start must release before next record
// - warn when pre plus post exceeds maximum
// - capture all configured analogue and binary channels
module drc_capture #(
  parameter int MS_TICK_CYCLES = drc_pkg::MS_CYCLES,
  parameter bit SELECTABLE_RATE = 1'b0
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [drc_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // trigger and sample sources
  input wire logic RECORD_START_CONDITION,
  input wire logic SAMPLE_TICK,
  input wire logic [drc_pkg::ANA_CH*drc_pkg::ANA_W-1:0] ANALOG_SAMPLES,
  input wire logic [drc_pkg::BIN_CH-1:0] BINARY_SAMPLES,
  // record memory write port
  output logic MEM_WE,
  output logic [drc_pkg::PTR_W-1:0] MEM_FRAME_ADDR,
  output logic [drc_pkg::FRAME_W-1:0] MEM_WDATA,
  // status
  output logic WARNING,
  output logic IRQ
);
  import drc_pkg::*;

  drc_state_type state;
  logic recorder_operation_setting;
  logic sample_rate_setting;
  logic [TIME_W-1:0] pre_trigger_time_setting;
  logic [TIME_W-1:0] post_trigger_time_setting;
  logic [TIME_W-1:0] max_record_time_setting;
  logic [ANA_CH-1:0] ana_enable;
  logic [BIN_CH-1:0] bin_enable;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rec_start;
  logic [PTR_W-1:0] rec_end;
  logic [15:0] rec_count;
  logic [16:0] ms_div;
  logic ms_tick;
  logic half;
  logic take_sample;
  logic released;
  logic warn_q;
  logic [TIME_W-1:0] sect_ms;
  logic [HIST_W-1:0] ms_idx;
  logic [HIST_W-1:0] hist_fill;
  logic [PTR_W-1:0] ms_hist [HIST_D];
  logic [PTR_W-1:0] oldest_ptr;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic trigger;
  logic sect_over;
  logic warn_now;
  logic [IRQ_W-1:0] events;
  logic [PTR_W-1:0] next_ptr;
  logic [HIST_W-1:0] pre_idx;
  logic [FRAME_W-1:0] frame;

  // clamp a timer write into its legal range
  function automatic logic [TIME_W-1:0] clamp_ms(input logic [31:0] v,
      input logic [TIME_W-1:0] lo, input logic [TIME_W-1:0] hi);
    logic [TIME_W-1:0] r;
    r = hi;
    if (v < 32'(lo)) begin
      r = lo;
    end else if (v < 32'(hi)) begin
      r = TIME_W'(v);
    end
    return r;
  endfunction : clamp_ms

  // apb decode: zero wait states, unmapped addresses answer with an error
  assign PREADY = 1'b1;
  assign wr_en = PSEL & PENABLE & PWRITE;
  assign rd_en = PSEL & ~PWRITE;
  always_comb begin
    mapped = 1'b1;
    case (PADDR)
      REG_CTRL, REG_PRE, REG_POST, REG_MAX, REG_ANA_EN, REG_BIN_EN_LO,
      REG_BIN_EN_HI, REG_STATUS, REG_IRQ_STAT, REG_IRQ_MASK,
      REG_REC_START, REG_REC_END, REG_REC_COUNT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  // settings registers; operation starts off so nothing records uncommanded
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      recorder_operation_setting <= 1'b0;
      sample_rate_setting <= 1'b0;
      pre_trigger_time_setting <= PRE_DEF;
      post_trigger_time_setting <= POST_DEF;
      max_record_time_setting <= MAXT_DEF;
      ana_enable <= '1;
      bin_enable <= '1;
      irq_mask <= '0;
    end else if (wr_en) begin
      case (PADDR)
        REG_CTRL: begin
          recorder_operation_setting <= PWDATA[CTRL_OPER];
          sample_rate_setting <= PWDATA[CTRL_RATE] & SELECTABLE_RATE;
        end
        REG_PRE: pre_trigger_time_setting <= clamp_ms(PWDATA, PRE_MIN, PRE_MAX);
        REG_POST: post_trigger_time_setting <= clamp_ms(PWDATA, POST_MIN, POST_MAX);
        REG_MAX: max_record_time_setting <= clamp_ms(PWDATA, MAXT_MIN, MAXT_MAX);
        REG_ANA_EN: ana_enable <= PWDATA;
        REG_BIN_EN_LO: bin_enable[31:0] <= PWDATA;
        REG_BIN_EN_HI: bin_enable[63:32] <= PWDATA;
        REG_IRQ_MASK: irq_mask <= PWDATA[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // read mux; registered so read data is stable through the access phase
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PRDATA <= '0;
    end else if (rd_en && !PENABLE) begin
      case (PADDR)
        REG_CTRL: PRDATA <= {30'h0, sample_rate_setting, recorder_operation_setting};
        REG_PRE: PRDATA <= {18'h0, pre_trigger_time_setting};
        REG_POST: PRDATA <= {18'h0, post_trigger_time_setting};
        REG_MAX: PRDATA <= {18'h0, max_record_time_setting};
        REG_ANA_EN: PRDATA <= ana_enable;
        REG_BIN_EN_LO: PRDATA <= bin_enable[31:0];
        REG_BIN_EN_HI: PRDATA <= bin_enable[63:32];
        REG_STATUS: PRDATA <= {28'h0, released, warn_q, state};
        REG_IRQ_STAT: PRDATA <= {29'h0, irq_status};
        REG_IRQ_MASK: PRDATA <= {29'h0, irq_mask};
        REG_REC_START: PRDATA <= {14'h0, rec_start};
        REG_REC_END: PRDATA <= {14'h0, rec_end};
        REG_REC_COUNT: PRDATA <= {16'h0, rec_count};
        default: PRDATA <= '0;
      endcase
    end
  end

  // settings consistency check, evaluated continuously
  assign warn_now = (15'(pre_trigger_time_setting) + 15'(post_trigger_time_setting))
                    > 15'(max_record_time_setting);
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      warn_q <= 1'b0;
    end else begin
      warn_q <= warn_now;
    end
  end
  assign WARNING = warn_q;

  // sticky events; a new event beats a same-cycle write-one-to-clear
  assign events[EV_WARN] = warn_now & ~warn_q;
  assign events[EV_START] = trigger;
  assign events[EV_DONE] = (state == DRC_POST) & sect_over;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_status <= '0;
    end else if (wr_en && PADDR == REG_IRQ_STAT) begin
      irq_status <= (irq_status & ~PWDATA[IRQ_W-1:0]) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end
  assign IRQ = |(irq_status & irq_mask);

  // 1 ms enable from a free-running divider
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ms_div <= '0;
    end else if (ms_div == 17'(MS_TICK_CYCLES - 1)) begin
      ms_div <= '0;
    end else begin
      ms_div <= ms_div + 17'h1;
    end
  end
  assign ms_tick = (ms_div == 17'(MS_TICK_CYCLES - 1));

  // sample ticks arrive at forty per period; low rate keeps every other one
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      half <= 1'b0;
    end else if (SAMPLE_TICK) begin
      half <= ~half;
    end
  end
  assign take_sample = SAMPLE_TICK & (sample_rate_setting | half)
                       & recorder_operation_setting;

  // frame assembly: disabled channels are written as zero
  always_comb begin
    frame = '0;
    for (int i = 0; i < ANA_CH; i++) begin
      if (ana_enable[i]) begin
        frame[i*ANA_W +: ANA_W] = ANALOG_SAMPLES[i*ANA_W +: ANA_W];
      end
    end
    frame[ANA_CH*ANA_W +: BIN_CH] = BINARY_SAMPLES & bin_enable;
  end

  // circular frame writer over the whole record memory
  assign next_ptr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + PTR_W'(1);
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_ptr <= '0;
      MEM_WE <= 1'b0;
      MEM_FRAME_ADDR <= '0;
      MEM_WDATA <= '0;
    end else begin
      MEM_WE <= take_sample;
      if (take_sample) begin
        MEM_FRAME_ADDR <= wr_ptr;
        MEM_WDATA <= frame;
        wr_ptr <= next_ptr;
      end
    end
  end

  // write pointer snapshot each ms, so the pre-trigger start can be found
  always_ff @(posedge CLK) begin
    if (ms_tick) begin
      ms_hist[ms_idx] <= wr_ptr;
    end
  end
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ms_idx <= '0;
      hist_fill <= '0;
      oldest_ptr <= '0;
    end else if (!recorder_operation_setting) begin
      hist_fill <= '0;
      oldest_ptr <= wr_ptr;
    end else if (ms_tick) begin
      ms_idx <= ms_idx + HIST_W'(1);
      if (hist_fill != '1) begin
        hist_fill <= hist_fill + HIST_W'(1);
      end
    end
  end
  // short history after enable: record starts at the oldest frame held
  assign pre_idx = ms_idx - HIST_W'(pre_trigger_time_setting);

  // trigger needs operation on, start true and a prior release
  assign trigger = (state == DRC_ARMED) & recorder_operation_setting
                   & RECORD_START_CONDITION & released;
  assign sect_over = (state == DRC_TRIG)
                     ? (sect_ms >= max_record_time_setting) | ~RECORD_START_CONDITION
                     : (sect_ms >= post_trigger_time_setting);

  // release tracking: start must go inactive between records
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      released <= 1'b0;
    end else if (!RECORD_START_CONDITION) begin
      released <= 1'b1;
    end else if (trigger) begin
      released <= 1'b0;
    end
  end

  // record sequencer: armed, triggered section, post section
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= DRC_OFF;
      sect_ms <= '0;
      rec_start <= '0;
      rec_end <= '0;
      rec_count <= '0;
    end else if (!recorder_operation_setting) begin
      state <= DRC_OFF;
      sect_ms <= '0;
    end else begin
      case (state)
        DRC_OFF: state <= DRC_ARMED;
        DRC_ARMED: begin
          sect_ms <= '0;
          if (trigger) begin
            state <= DRC_TRIG;
            rec_start <= (hist_fill > HIST_W'(pre_trigger_time_setting))
                         ? ms_hist[pre_idx] : oldest_ptr;
          end
        end
        DRC_TRIG: begin
          if (sect_over) begin
            state <= DRC_POST;
            sect_ms <= '0;
          end else if (ms_tick) begin
            sect_ms <= sect_ms + TIME_W'(1);
          end
        end
        DRC_POST: begin
          if (sect_over) begin
            state <= DRC_ARMED;
            rec_end <= wr_ptr;
            rec_count <= rec_count + 16'h1;
          end else if (ms_tick) begin
            sect_ms <= sect_ms + TIME_W'(1);
          end
        end
        default: state <= DRC_OFF;
      endcase
    end
  end
endmodule : drc_capture
`default_nettype wire

// [drc_capture_sva.sv]
/*
  Port checker for drc_capture, bound to every instance.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module drc_capture_sva
  import drc_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES,
  parameter bit SELECTABLE_RATE = 1'b0
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  // samples, memory and status
  input wire logic SAMPLE_TICK,
  input wire logic MEM_WE,
  input wire logic [PTR_W-1:0] MEM_FRAME_ADDR,
  input wire logic [FRAME_W-1:0] MEM_WDATA,
  input wire logic WARNING,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  logic [PTR_W-1:0] last_addr;
  logic seen_we;
  logic oper_q;
  // last frame index, and a mirror of the operation bit as software wrote it
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      last_addr <= '0;
      seen_we <= 1'b0;
      oper_q <= 1'b0;
    end else begin
      if (MEM_WE) last_addr <= MEM_FRAME_ADDR;
      seen_we <= seen_we | MEM_WE;
      if (PSEL && PENABLE && PWRITE && PADDR == REG_CTRL) oper_q <= PWDATA[CTRL_OPER];
    end
  end
  a_we_tick: assert property (MEM_WE |-> $past(SAMPLE_TICK))
    else $error("write without tick");
  a_we_single: assert property (MEM_WE |=> !MEM_WE)
    else $error("write too long");
  a_frame_hold: assert property (!MEM_WE |-> $stable(MEM_FRAME_ADDR) && $stable(MEM_WDATA))
    else $error("frame moved");
  a_ring_order: assert property (MEM_WE && seen_we |->
    MEM_FRAME_ADDR == ((last_addr == PTR_LAST) ? '0 : last_addr + 1'b1))
    else $error("ring order");
  a_addr_range: assert property (MEM_FRAME_ADDR <= PTR_LAST)
    else $error("beyond memory");
  a_off_quiet: assert property (MEM_WE |-> $past(oper_q))
    else $error("write while operation off");
  a_warn_cause: assert property ($changed(WARNING) |-> $past(PSEL && PENABLE && PWRITE, 2))
    else $error("warning without write");
  a_err_phase: assert property (PSLVERR |-> PSEL && PENABLE && (PWRITE || PRDATA == 32'h0))
    else $error("error outside access");
  c_write: cover property (MEM_WE);
  c_warn: cover property ($rose(WARNING));
  c_irq: cover property ($rose(IRQ));
endmodule : drc_capture_sva
bind drc_capture drc_capture_sva #(.MS_TICK_CYCLES(MS_TICK_CYCLES),
  .SELECTABLE_RATE(SELECTABLE_RATE)) u_drc_capture_sva (.CLK(CLK), .RESET_N(RESET_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PSLVERR(PSLVERR),
  .SAMPLE_TICK(SAMPLE_TICK), .MEM_WE(MEM_WE), .MEM_FRAME_ADDR(MEM_FRAME_ADDR),
  .MEM_WDATA(MEM_WDATA), .WARNING(WARNING), .IRQ(IRQ));
`default_nettype wire

// [drc_src_model.sv]
/*
  Source model: user start logic and sampled channel feed.
  Assumes the capture block runs on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module drc_src_model
  import drc_pkg::*;
#(
  parameter int TICK_GAP = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bench request
  input wire logic start_req,
  // towards the capture block
  output logic start_cond,
  output logic tick,
  output logic [ANA_CH*ANA_W-1:0] ana,
  output logic [BIN_CH-1:0] bin
);
  logic [7:0] gap;
  logic [15:0] seq;
  // start level follows the bench, which must drop it before a retrigger
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) start_cond <= 1'b0;
    else start_cond <= start_req;
  end
  // new distinct value on every analogue channel per tick, so a stale frame shows
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap <= 8'h00;
      seq <= 16'h0000;
      tick <= 1'b0;
      ana <= '0;
      bin <= '0;
    end else begin
      tick <= (gap == 8'(TICK_GAP - 1));
      gap <= (gap == 8'(TICK_GAP - 1)) ? 8'h00 : gap + 8'h01;
      if (gap == 8'(TICK_GAP - 1)) begin
        seq <= seq + 16'h0001;
        bin <= {seq, ~seq, seq ^ 16'h5A5A, seq};
        for (int i = 0; i < ANA_CH; i++) ana[ANA_W*i +: ANA_W] <= seq + 16'(i);
      end
    end
  end
endmodule : drc_src_model
`default_nettype wire

// [testbench.sv]
/*
  Bench for drc_capture: settings, warning, interrupt, masks,
  rate and record timing. The source model feeds samples.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import drc_pkg::*;
  logic CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, MEM_WE, WARNING, IRQ;
  logic RECORD_START_CONDITION, SAMPLE_TICK, start_req, err;
  logic [ADDR_W-1:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd, ana_en;
  logic [BIN_CH-1:0] BINARY_SAMPLES, bin_en;
  logic [ANA_CH*ANA_W-1:0] ANALOG_SAMPLES;
  logic [PTR_W-1:0] MEM_FRAME_ADDR;
  logic [FRAME_W-1:0] MEM_WDATA;
  int error_cnt = 0;
  int compares = 0;
  int we_cnt = 0;
  int cyc = 0;
  int t0;
  // ms divider cut to 10 cycles to keep records short
  drc_capture #(.MS_TICK_CYCLES(10), .SELECTABLE_RATE(1'b0)) u_drc_capture (
    .CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RECORD_START_CONDITION(RECORD_START_CONDITION), .SAMPLE_TICK(SAMPLE_TICK),
    .ANALOG_SAMPLES(ANALOG_SAMPLES), .BINARY_SAMPLES(BINARY_SAMPLES), .MEM_WE(MEM_WE),
    .MEM_FRAME_ADDR(MEM_FRAME_ADDR), .MEM_WDATA(MEM_WDATA), .WARNING(WARNING), .IRQ(IRQ));
  drc_src_model u_drc_src_model (.clk(CLK), .reset_n(RESET_N), .start_req(start_req),
    .start_cond(RECORD_START_CONDITION), .tick(SAMPLE_TICK), .ana(ANALOG_SAMPLES),
    .bin(BINARY_SAMPLES));
  // clock
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic chk(input logic [FRAME_W-1:0] g, input logic [FRAME_W-1:0] e, string m);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic chk_n(input int g, input int lo, input int hi, input string m);
    chk(FRAME_W'(g >= lo && g <= hi), FRAME_W'(1), m);
  endtask : chk_n
  function automatic logic [FRAME_W-1:0] frame(input logic [FRAME_W-1:0] f);
    f[FRAME_W-1 -: BIN_CH] &= bin_en;
    for (int i = 0; i < ANA_CH; i++) if (!ana_en[i]) f[ANA_W*i +: ANA_W] = '0;
    return f;
  endfunction : frame
  // every written frame must be the source, masked by the enables
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (MEM_WE === 1'b1) begin
      we_cnt <= we_cnt + 1;
      chk(MEM_WDATA, frame({BINARY_SAMPLES, ANALOG_SAMPLES}), "frame");
    end
  end
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(FRAME_W'(rd), FRAME_W'(e), m);
  endtask : rc
  task automatic wait_st(input logic [1:0] s, input int n);
    apb(1'b0, REG_STATUS, 32'h0);
    for (int i = 0; i < n && rd[1:0] !== s; i++) apb(1'b0, REG_STATUS, 32'h0);
    chk(FRAME_W'(rd[1:0]), FRAME_W'(s), "state");
  endtask : wait_st
  task automatic t_settings();
    logic [ADDR_W-1:0] a[4] = '{REG_PRE, REG_POST, REG_MAX, REG_MAX};
    logic [31:0] w[4] = '{32'h63, 32'h3E9, 32'h1F3, 32'h2711};
    logic [31:0] e[4] = '{32'(PRE_MIN), 32'(POST_MAX), 32'(MAXT_MIN), 32'(MAXT_MAX)};
    rc(REG_CTRL, 32'h0, "ctrl");
    rc(REG_PRE, 32'(PRE_DEF), "pre");
    rc(REG_POST, 32'(POST_DEF), "post");
    rc(REG_MAX, 32'(MAXT_DEF), "max");
    rc(REG_BIN_EN_HI, 32'hFFFFFFFF, "bin en");
    rc(8'h3C, 32'h0, "unmapped");
    chk(FRAME_W'(err), FRAME_W'(1), "slverr");
    apb(1'b1, REG_CTRL, 32'h2);
    rc(REG_CTRL, 32'h0, "rate");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, a[i], w[i]);
      rc(a[i], e[i], "clamp");
    end
    $display("t_settings done");
  endtask : t_settings
  task automatic t_warn();
    apb(1'b1, REG_MAX, 32'h3E8);
    apb(1'b1, REG_PRE, 32'h1F4);
    apb(1'b1, REG_POST, 32'h1F4);
    repeat (3) @(posedge CLK);
    chk(FRAME_W'(WARNING), FRAME_W'(0), "sum equal");
    apb(1'b1, REG_POST, 32'h1F5);
    repeat (3) @(posedge CLK);
    chk(FRAME_W'(WARNING), FRAME_W'(1), "sum above");
    chk(FRAME_W'(IRQ), FRAME_W'(0), "irq masked");
    apb(1'b1, REG_IRQ_MASK, 32'h4);
    @(negedge CLK);
    chk(FRAME_W'(IRQ), FRAME_W'(1), "irq set");
    apb(1'b1, REG_IRQ_STAT, 32'h4);
    @(negedge CLK);
    chk(FRAME_W'(IRQ), FRAME_W'(0), "irq clear");
    apb(1'b1, REG_POST, 32'h64);
    apb(1'b1, REG_PRE, 32'h64);
    apb(1'b1, REG_MAX, 32'h1F4);
    repeat (3) @(posedge CLK);
    chk(FRAME_W'(WARNING), FRAME_W'(0), "warn gone");
    $display("t_warn done");
  endtask : t_warn
  task automatic t_chan();
    apb(1'b1, REG_ANA_EN, 32'hA5A50F0F);
    apb(1'b1, REG_BIN_EN_LO, 32'h0000FFFF);
    ana_en = 32'hA5A50F0F;
    bin_en = 64'hFFFFFFFF0000FFFF;
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (20) @(posedge CLK);
    t0 = we_cnt;
    repeat (80) @(posedge CLK);
    chk_n(we_cnt - t0, 10, 10, "base rate");
    apb(1'b1, REG_CTRL, 32'h0);
    start_req <= 1'b1;
    repeat (5) @(posedge CLK);
    t0 = we_cnt;
    repeat (100) @(posedge CLK);
    chk_n(we_cnt - t0, 0, 0, "off writes");
    wait_st(2'd0, 1);
    start_req <= 1'b0;
    apb(1'b1, REG_ANA_EN, 32'hFFFFFFFF);
    apb(1'b1, REG_BIN_EN_LO, 32'hFFFFFFFF);
    ana_en = '1;
    bin_en = '1;
    $display("t_chan done");
  endtask : t_chan
  task automatic t_record();
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (1500) @(posedge CLK);
    start_req <= 1'b1;
    t0 = cyc;
    wait_st(2'd2, 4);
    wait_st(2'd3, 2000);
    chk_n(cyc - t0, 4980, 5040, "max limit");
    t0 = cyc;
    wait_st(2'd1, 500);
    chk_n(cyc - t0, 990, 1030, "post time");
    apb(1'b0, REG_REC_END, 32'h0);
    t0 = int'(rd);
    apb(1'b0, REG_REC_START, 32'h0);
    chk_n(t0 - int'(rd), 865, 885, "length");
    repeat (100) @(posedge CLK);
    wait_st(2'd1, 1);
    start_req <= 1'b0;
    repeat (10) @(posedge CLK);
    start_req <= 1'b1;
    wait_st(2'd2, 4);
    repeat (300) @(posedge CLK);
    start_req <= 1'b0;
    wait_st(2'd3, 4);
    wait_st(2'd1, 500);
    rc(REG_REC_COUNT, 32'h2, "count");
    rc(REG_IRQ_STAT, 32'h3, "events");
    apb(1'b1, REG_IRQ_MASK, 32'h3);
    @(negedge CLK);
    chk(FRAME_W'(IRQ), FRAME_W'(1), "irq");
    apb(1'b1, REG_IRQ_STAT, 32'h3);
    @(negedge CLK);
    chk(FRAME_W'(IRQ), FRAME_W'(0), "irq w1c");
    $display("t_record done");
  endtask : t_record
  task automatic end_of_test();
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // main sequence
  initial begin
    RESET_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = '0;
    PWDATA = '0;
    start_req = 1'b0;
    ana_en = '1;
    bin_en = '1;
    repeat (5) @(posedge CLK);
    RESET_N <= 1'b1;
    t_settings();
    t_warn();
    t_chan();
    t_record();
    end_of_test();
  end
  // tests take about 9k cycles
  initial begin
    repeat (40000) @(posedge CLK);
    error_cnt++;
    $display("[FAIL] %0t watchdog", $time);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
